// *** src/sync_serial_channel.v ***
`timescale 1ns/1ps
`include "sync_serial_map.vh"

module sync_serial_channel #(
    parameter CHANNEL = 0
) (
    input wire mclk_i,
    input wire reset_i,
    input wire [2:0] serial_mode_field_i,
    input wire clock_origin_select_i,
    input wire [1:0] clock_source_select_i,
    input wire [7:0] rate_divider_i,
    input wire handshake_enable_i,
    input wire handshake_rts_select_i,
    input wire clock_edge_select_i,
    input wire bit_order_select_i,
    input wire data_invert_select_i,
    input wire open_drain_select_i,
    input wire tx_allow_bit_i,
    input wire rx_allow_bit_i,
    input wire [7:0] shared_serial_control_i,
    input wire [7:0] serial_control_1_i,
    input wire tx_write_i,
    input wire [7:0] tx_data_i,
    input wire rx_read_i,
    input wire transfer_clock_pin_i,
    input wire rxd_i,
    input wire cts_i,
    input wire cts_alt_i,
    output reg txd_o,
    output reg txd_oe_n_o,
    output reg transfer_clock_pin_o,
    output reg transfer_clock_pin_oe_n_o,
    output reg transfer_clock_alt_o,
    output reg transfer_clock_alt_oe_n_o,
    output reg rts_o,
    output reg rts_oe_n_o,
    output reg tx_buffer_vacant_flag_o,
    output reg tx_shift_empty_o,
    output reg [7:0] rx_holding_reg_o,
    output reg rx_full_o,
    output reg overrun_o,
    output reg tx_irq_o,
    output reg rx_irq_o
);

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    function out_bit;
        input [7:0] word;
        input msb_first;
        begin
            out_bit = msb_first ? word[7] : word[0];
        end
    endfunction

    function [7:0] shift_word;
        input [7:0] word;
        input in_bit;
        input msb_first;
        begin
            shift_word = msb_first ? {word[6:0], in_bit} : {in_bit, word[7:1]};
        end
    endfunction

    //------------------------------------------------------------
    // Per-channel option selection
    //------------------------------------------------------------
    wire mode_on = (serial_mode_field_i == `MODE_SYNC);
    wire irs_sel = (CHANNEL == 2) ? serial_control_1_i[`C1_IRS_BIT] :
                   (CHANNEL == 1) ? shared_serial_control_i[`SHARED_IRS1_BIT] :
                   shared_serial_control_i[`SHARED_IRS0_BIT];
    wire rrm_sel = (CHANNEL == 2) ? serial_control_1_i[`C1_RRM_BIT] :
                   (CHANNEL == 1) ? shared_serial_control_i[`SHARED_RRM1_BIT] :
                   shared_serial_control_i[`SHARED_RRM0_BIT];
    wire multi_clk = (CHANNEL == 1) && shared_serial_control_i[`SHARED_CLKMD1_BIT] &&
                     !clock_origin_select_i;
    wire use_alt_clk = multi_clk && shared_serial_control_i[`SHARED_CLKMD0_BIT];
    wire split_cts = (CHANNEL == 0) && shared_serial_control_i[`SHARED_SPLIT_BIT];
    wire cts_mode = handshake_enable_i && !handshake_rts_select_i;
    wire rts_mode = handshake_enable_i && (handshake_rts_select_i || split_cts);
    wire cts_level = split_cts ? cts_alt_i : cts_i;
    wire idle_level = ~clock_edge_select_i;

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;

    reg state_ff;
    reg [4:0] prescale_ff;
    reg [7:0] rate_cnt_ff;
    reg int_clk_ff;
    reg ext_clk_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] tx_hold_ff;
    reg [7:0] tx_shift_ff;
    reg [7:0] rx_shift_ff;
    reg rx_active_ff;
    reg rearm_ff;
    reg word_overrun_ff;

    //------------------------------------------------------------
    // Internal rate generation
    //------------------------------------------------------------
    reg src_tick;
    always @* begin
        case (clock_source_select_i)
            `SRC_UNDIV: src_tick = 1'b1;
            `SRC_HALF: src_tick = ((prescale_ff & `PRESCALE_HALF_MASK) == `PRESCALE_HALF_MASK);
            `SRC_EIGHTH: src_tick = ((prescale_ff & `PRESCALE_EIGHTH_MASK) == `PRESCALE_EIGHTH_MASK);
            `SRC_THIRTYSECOND: src_tick = (prescale_ff == `PRESCALE_THIRTYSECOND_MASK);
            default: src_tick = 1'b1;
        endcase
    end

    // Each half period spans n+1 source ticks
    wire half_tick = src_tick && (rate_cnt_ff == 8'h00);

    //------------------------------------------------------------
    // Transfer clock edges
    //------------------------------------------------------------
    wire ext_lead = (ext_clk_ff == idle_level) && (transfer_clock_pin_i != idle_level);
    wire ext_trail = (ext_clk_ff != idle_level) && (transfer_clock_pin_i == idle_level);
    wire int_lead = half_tick && (int_clk_ff == idle_level);
    wire int_trail = half_tick && (int_clk_ff != idle_level);
    wire active = (state_ff == ST_SHIFT);
    // Leading edge away from idle drives, return to idle samples
    wire drive_edge = active && (clock_origin_select_i ? ext_lead : int_lead);
    wire sample_edge = active && (clock_origin_select_i ? ext_trail : int_trail);
    wire last_sample = sample_edge && (bit_cnt_ff == `WORD_BITS - 4'h1);

    //------------------------------------------------------------
    // Start decision
    //------------------------------------------------------------
    wire cts_ok = !cts_mode || !cts_level;
    wire tx_ready = !tx_buffer_vacant_flag_o;
    wire cont_ready = rrm_sel && rearm_ff && rx_allow_bit_i;
    wire ext_idle_ok = !clock_origin_select_i || (transfer_clock_pin_i == idle_level);
    wire start = !active && mode_on && tx_allow_bit_i && cts_ok && ext_idle_ok &&
                 (tx_ready || cont_ready);
    wire start_rx = rx_allow_bit_i;
    wire rx_bit = rxd_i ^ data_invert_select_i;

    //------------------------------------------------------------
    // Sequencing
    //------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            prescale_ff <= `PRESCALE_RESET;
            rate_cnt_ff <= 8'h00;
            int_clk_ff <= 1'b1;
            ext_clk_ff <= 1'b1;
            bit_cnt_ff <= 4'h0;
            tx_hold_ff <= 8'h00;
            tx_shift_ff <= 8'h00;
            rx_shift_ff <= 8'h00;
            rx_active_ff <= 1'b0;
            rearm_ff <= 1'b0;
            word_overrun_ff <= 1'b0;
            txd_o <= 1'b1;
            tx_buffer_vacant_flag_o <= 1'b1;
            tx_shift_empty_o <= 1'b1;
            rx_holding_reg_o <= 8'h00;
            rx_full_o <= 1'b0;
            overrun_o <= 1'b0;
            tx_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;
        end else begin
            prescale_ff <= prescale_ff + 5'h01;
            ext_clk_ff <= transfer_clock_pin_i;
            tx_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;

            if (!active || src_tick && rate_cnt_ff == 8'h00)
                rate_cnt_ff <= rate_divider_i;
            else if (src_tick)
                rate_cnt_ff <= rate_cnt_ff - 8'h01;

            if (!active)
                int_clk_ff <= idle_level;
            else if (half_tick && !clock_origin_select_i)
                int_clk_ff <= ~int_clk_ff;

            if (tx_write_i) begin
                tx_hold_ff <= tx_data_i;
                tx_buffer_vacant_flag_o <= 1'b0;
            end

            if (rrm_sel && rx_read_i)
                rearm_ff <= 1'b1;

            // Read clears the full flag unless a new word lands now
            if (rx_read_i)
                rx_full_o <= 1'b0;

            if (!mode_on) begin
                state_ff <= ST_IDLE;
                txd_o <= 1'b1;
                tx_shift_empty_o <= 1'b1;
                overrun_o <= 1'b0;
                bit_cnt_ff <= 4'h0;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        if (start) begin
                            state_ff <= ST_SHIFT;
                            bit_cnt_ff <= 4'h0;
                            rearm_ff <= 1'b0;
                            word_overrun_ff <= 1'b0;
                            rx_active_ff <= start_rx;
                            tx_shift_empty_o <= 1'b0;
                            tx_shift_ff <= tx_ready ? tx_hold_ff : tx_shift_ff;
                            if (tx_ready) begin
                                if (!tx_write_i)
                                    tx_buffer_vacant_flag_o <= 1'b1;
                                tx_irq_o <= !irs_sel;
                            end
                        end
                    end
                    ST_SHIFT: begin
                        if (drive_edge) begin
                            txd_o <= out_bit(tx_shift_ff, bit_order_select_i) ^ data_invert_select_i;
                            tx_shift_ff <= shift_word(tx_shift_ff, 1'b0, bit_order_select_i);
                        end
                        if (sample_edge) begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            rx_shift_ff <= shift_word(rx_shift_ff, rx_bit, bit_order_select_i);
                            if (rx_active_ff && rx_full_o && !rx_read_i &&
                                bit_cnt_ff == `OVERRUN_BIT - 4'h1) begin
                                overrun_o <= 1'b1;
                                word_overrun_ff <= 1'b1;
                            end
                        end
                        if (last_sample) begin
                            state_ff <= ST_IDLE;
                            tx_shift_empty_o <= 1'b1;
                            tx_irq_o <= irs_sel;
                            if (rx_active_ff) begin
                                rx_holding_reg_o <= shift_word(rx_shift_ff, rx_bit, bit_order_select_i);
                                rx_full_o <= 1'b1;
                                rx_irq_o <= !word_overrun_ff;
                            end
                            rx_active_ff <= 1'b0;
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // Pin drivers
    //------------------------------------------------------------
    wire ready_rx = rx_allow_bit_i && !rx_active_ff && !rx_full_o;
    wire nxt_clk = active ? (half_tick ? ~int_clk_ff : int_clk_ff) : idle_level;
    wire nxt_txd_high = !mode_on ||
                        (drive_edge ? (out_bit(tx_shift_ff, bit_order_select_i) ^ data_invert_select_i) : txd_o);

    always @(posedge mclk_i) begin
        if (reset_i) begin
            txd_oe_n_o <= 1'b1;
            transfer_clock_pin_o <= 1'b1;
            transfer_clock_pin_oe_n_o <= 1'b1;
            transfer_clock_alt_o <= 1'b1;
            transfer_clock_alt_oe_n_o <= 1'b1;
            rts_o <= 1'b1;
            rts_oe_n_o <= 1'b1;
        end else begin
            // Open drain releases the line for a high level
            txd_oe_n_o <= !mode_on || (open_drain_select_i && nxt_txd_high);
            transfer_clock_pin_o <= nxt_clk;
            transfer_clock_alt_o <= nxt_clk;
            transfer_clock_pin_oe_n_o <= !(mode_on && !clock_origin_select_i && !use_alt_clk);
            transfer_clock_alt_oe_n_o <= !(mode_on && use_alt_clk);
            rts_o <= !(ready_rx && !(start && start_rx));
            rts_oe_n_o <= !(mode_on && rts_mode);
        end
    end

endmodule // sync_serial_channel

// *** src/sync_serial_map.vh ***
`ifndef SYNC_SERIAL_MAP_VH
`define SYNC_SERIAL_MAP_VH
//----------------------------------------------------------------
// Operation
//----------------------------------------------------------------
// Operation
// - Every transfer moves one plain 8-bit word, no start, stop or parity bits.
// - Internal transfer clock is the chosen prescaled source divided by 2(n+1).
// - Clock origin select 1 takes the transfer clock from the external pin.
// - Handshake is selectable: CTS input, RTS output or disabled.
// - Transmit starts with transmit allowed, buffer full and, if selected, CTS low.
// - Receive starts with receive allowed, transmit allowed and either buffer full or continuous receive re-armed.
// - Cause select 0: transmit interrupt when the buffer loads the shifter.
// - Cause select 1: transmit interrupt when the shifter has finished its word.
// - Receive interrupt when a finished word moves into the receive buffer.
// - Overrun when the buffer is unread and the next word's seventh bit arrives.
// - On overrun the buffer is undefined and no receive interrupt is raised.
// - Edge select 0 drives on falling, samples on rising; 1 swaps the edges.
// - Bit order selects LSB first or MSB first for both directions.
// - Continuous receive: reading the receive buffer re-arms reception by itself.
// - Data inversion flips every transmitted and received bit.
// - Channel 1 may send its transfer clock out on one of two pins.
// - Channel 0 may split CTS input and RTS output onto separate pins.
// - Cause selects sit in shared control bits 0 and 1, channel 2 in control 1 bit 4.
// - Mode field 001 selects synchronous mode; 000 disables the channel.
// - Before the first transfer the transmit line is high or released.

//----------------------------------------------------------------
// Field values and positions
//----------------------------------------------------------------
`define MODE_OFF 3'h0
`define MODE_SYNC 3'h1
`define SRC_UNDIV 2'h0
`define SRC_HALF 2'h1
`define SRC_EIGHTH 2'h2
`define SRC_THIRTYSECOND 2'h3
`define WORD_BITS 4'h8
`define OVERRUN_BIT 4'h7
`define SHARED_IRS0_BIT 0
`define SHARED_IRS1_BIT 1
`define SHARED_RRM0_BIT 2
`define SHARED_RRM1_BIT 3
`define SHARED_CLKMD0_BIT 4
`define SHARED_CLKMD1_BIT 5
`define SHARED_SPLIT_BIT 6
`define C1_IRS_BIT 4
`define C1_RRM_BIT 5
`define PRESCALE_RESET 5'h00
`define PRESCALE_HALF_MASK 5'h01
`define PRESCALE_EIGHTH_MASK 5'h07
`define PRESCALE_THIRTYSECOND_MASK 5'h1F

`endif

// *** verif/clock_sync_serial_mode_bench.sv ***
`timescale 1ns/1ps
// ----
// Bench
// ----
module clock_sync_serial_mode_bench;
    reg mclk_i, reset_i, clock_origin_select_i, handshake_enable_i, clock_edge_select_i, bit_order_select_i;
    reg data_invert_select_i, tx_allow_bit_i, rx_allow_bit_i, tx_write_i, rx_read_i, cts_i, go;
    reg [2:0] serial_mode_field_i;
    reg [1:0] clock_source_select_i;
    reg [7:0] rate_divider_i, shared_serial_control_i, tx_data_i, send;
    wire txd_o, transfer_clock_pin_o, tx_buffer_vacant_flag_o, tx_shift_empty_o, rx_full_o, overrun_o;
    wire tx_irq_o, rx_irq_o, rxd_i, ext_clk;
    wire txd_oe_n_o, transfer_clock_pin_oe_n_o, rts_o, rts_oe_n_o;
    wire [7:0] rx_holding_reg_o, got;
    integer error_cnt = 0, checks = 0, txi = 0, rxi = 0, cyc = 0;
    sync_serial_channel u_dut (.mclk_i, .reset_i, .serial_mode_field_i, .clock_origin_select_i,
        .clock_source_select_i, .rate_divider_i, .handshake_enable_i, .handshake_rts_select_i(1'b0),
        .clock_edge_select_i, .bit_order_select_i, .data_invert_select_i, .open_drain_select_i(1'b0),
        .tx_allow_bit_i, .rx_allow_bit_i, .shared_serial_control_i, .serial_control_1_i(8'h00), .tx_write_i,
        .tx_data_i, .rx_read_i, .transfer_clock_pin_i(ext_clk), .rxd_i, .cts_i, .cts_alt_i(1'b1), .txd_o,
        .txd_oe_n_o, .transfer_clock_pin_o, .transfer_clock_pin_oe_n_o, .transfer_clock_alt_o(),
        .transfer_clock_alt_oe_n_o(), .rts_o, .rts_oe_n_o, .tx_buffer_vacant_flag_o, .tx_shift_empty_o,
        .rx_holding_reg_o, .rx_full_o, .overrun_o, .tx_irq_o, .rx_irq_o);
    sync_peer u_peer (.mclk_i, .reset_i, .line_i(clock_origin_select_i ? ext_clk : transfer_clock_pin_o),
        .idle_i(!clock_edge_select_i), .txd_i(txd_o), .go_i(go), .send_i(send), .rxd_o(rxd_i),
        .ext_clk_o(ext_clk), .got_o(got));
    always @(posedge mclk_i) begin
        if (tx_irq_o === 1'b1) txi = txi + 1;
        if (rx_irq_o === 1'b1) rxi = rxi + 1;
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge mclk_i);
            #1;
        end
    endtask
    task put(input [7:0] d);
        begin
            tx_data_i = d;
            tx_write_i = 1'b1;
            step(1);
            tx_write_i = 1'b0;
        end
    endtask
    task rd;
        begin
            rx_read_i = 1'b1;
            step(1);
            rx_read_i = 1'b0;
        end
    endtask
    task finish_test;
        begin
            $display("checks=%0d error_cnt=%0d", checks, error_cnt);
            if (error_cnt == 0 && checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // Waits for a word to start and finish, counting its length
    task run;
        integer i;
        begin
            txi = 0;
            rxi = 0;
            cyc = 0;
            i = 0;
            while (tx_shift_empty_o !== 1'b0 && i < 30) begin
                step(1);
                i = i + 1;
            end
            if (clock_origin_select_i) begin
                go = 1'b1;
                step(1);
                go = 1'b0;
            end
            while (tx_shift_empty_o !== 1'b1 && cyc < 3000) begin
                step(1);
                cyc = cyc + 1;
            end
            // Lets the peer take the last bit and the bench count the end pulses
            step(1);
            if (i >= 30 || cyc >= 3000) begin
                $display("[FAIL] t=%0t wait limit", $time);
                error_cnt = error_cnt + 1;
                finish_test;
            end
        end
    endtask
    task t_basic;
        begin
            send = 8'h3C;
            put(8'hA5);
            run;
            check(got, 8'hA5);
            check(rx_holding_reg_o, 8'h3C);
            check(txi[7:0], 8'h01);
            check(rxi[7:0], 8'h01);
            check({7'h00, cyc >= 94 && cyc <= 108}, 8'h01);
            check({7'h00, rts_o}, 8'h01);
            rd;
            $display("test basic done");
        end
    endtask
    task t_alt;
        begin
            clock_source_select_i = 2'h2;
            rate_divider_i = 8'h00;
            shared_serial_control_i = 8'h01;
            clock_edge_select_i = 1'b1;
            bit_order_select_i = 1'b1;
            data_invert_select_i = 1'b1;
            step(3);
            send = 8'h03;
            put(8'h1E);
            run;
            check(got, 8'h87);
            check(rx_holding_reg_o, 8'h3F);
            check(txi[7:0], 8'h01);
            check({7'h00, cyc >= 121 && cyc <= 128}, 8'h01);
            rd;
            {clock_source_select_i, shared_serial_control_i, clock_edge_select_i} = 11'h000;
            {bit_order_select_i, data_invert_select_i, rate_divider_i} = 10'h005;
            step(3);
            $display("test alt done");
        end
    endtask
    task t_overrun;
        begin
            put(8'h11);
            run;
            put(8'h22);
            run;
            check({7'h00, overrun_o}, 8'h01);
            check(rxi[7:0], 8'h00);
            rd;
            $display("test overrun done");
        end
    endtask
    task t_gate;
        begin
            serial_mode_field_i = 3'h0;
            put(8'h5A);
            step(20);
            check({7'h00, tx_shift_empty_o}, 8'h01);
            serial_mode_field_i = 3'h1;
            tx_allow_bit_i = 1'b0;
            put(8'h5A);
            step(20);
            check({7'h00, tx_shift_empty_o}, 8'h01);
            cts_i = 1'b1;
            handshake_enable_i = 1'b1;
            tx_allow_bit_i = 1'b1;
            step(20);
            check({7'h00, tx_shift_empty_o}, 8'h01);
            cts_i = 1'b0;
            run;
            check(rxi[7:0], 8'h01);
            handshake_enable_i = 1'b0;
            rd;
            $display("test gate done");
        end
    endtask
    task t_ext;
        begin
            clock_origin_select_i = 1'b1;
            step(3);
            send = 8'h5A;
            put(8'hC3);
            run;
            check(got, 8'hC3);
            check(rx_holding_reg_o, 8'h5A);
            clock_origin_select_i = 1'b0;
            rd;
            shared_serial_control_i = 8'h04;
            put(8'h0F);
            run;
            rd;
            run;
            check(rxi[7:0], 8'h01);
            shared_serial_control_i = 8'h00;
            rd;
            $display("test ext and continuous done");
        end
    endtask
    initial begin
        {mclk_i, clock_origin_select_i, handshake_enable_i, clock_edge_select_i, bit_order_select_i} = 5'h00;
        {data_invert_select_i, tx_write_i, rx_read_i, cts_i, go, serial_mode_field_i} = 8'h00;
        {clock_source_select_i, shared_serial_control_i, tx_data_i, send} = 26'h0;
        {tx_allow_bit_i, rx_allow_bit_i, rate_divider_i} = 10'h305;
        reset_i = 1'b1;
        step(12);
        reset_i = 1'b0;
        check({txd_o, tx_buffer_vacant_flag_o, tx_shift_empty_o, rx_full_o, overrun_o, txd_oe_n_o, rts_o, rts_oe_n_o},
            8'hE7);
        serial_mode_field_i = 3'h1;
        step(3);
        check({rx_holding_reg_o[6:0], txd_o}, 8'h01);
        check({4'h0, txd_oe_n_o, transfer_clock_pin_oe_n_o, rts_o, rts_oe_n_o}, 8'h01);
        t_basic;
        t_alt;
        t_overrun;
        t_gate;
        t_ext;
        finish_test;
    end
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
endmodule // clock_sync_serial_mode_bench

// *** verif/sync_peer.sv ***
`timescale 1ns/1ps
// ----
// Far-end synchronous peer
// ----
module sync_peer (
    input wire mclk_i,
    input wire reset_i,
    input wire line_i,
    input wire idle_i,
    input wire txd_i,
    input wire go_i,
    input wire [7:0] send_i,
    output reg rxd_o,
    output reg ext_clk_o,
    output reg [7:0] got_o
);
    reg prev_ff;
    reg [3:0] idx_ff;
    reg [4:0] tog_ff;
    reg [3:0] cnt_ff;
    always @(posedge mclk_i) begin
        prev_ff <= line_i;
        if (reset_i) begin
            idx_ff <= 4'h0;
            rxd_o <= 1'b1;
        end else if (prev_ff == idle_i && line_i != idle_i) begin
            rxd_o <= send_i[idx_ff[2:0]];
            idx_ff <= idx_ff + 4'h1;
        end else if (prev_ff != idle_i && line_i == idle_i) begin
            got_o <= {txd_i, got_o[7:1]};
            if (idx_ff == 4'h8) begin
                idx_ff <= 4'h0;
                rxd_o <= ~rxd_o;
            end
        end
    end
    // Sixteen half periods of 8 cycles, parked at idle between words
    always @(posedge mclk_i) begin
        if (reset_i || tog_ff == 5'h00) begin
            ext_clk_o <= idle_i;
            tog_ff <= go_i ? 5'h10 : 5'h00;
            cnt_ff <= 4'h7;
        end else if (cnt_ff == 4'h0) begin
            ext_clk_o <= ~ext_clk_o;
            tog_ff <= tog_ff - 5'h01;
            cnt_ff <= 4'h7;
        end else begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule // sync_peer

// *** verif/sync_serial_sva.sv ***
`timescale 1ns/1ps
// ----
// Port checker
// ----
module sync_serial_sva #(
    parameter CHANNEL = 0
) (
    input wire mclk_i,
    input wire reset_i,
    input wire [2:0] serial_mode_field_i,
    input wire clock_origin_select_i,
    input wire clock_edge_select_i,
    input wire handshake_enable_i,
    input wire handshake_rts_select_i,
    input wire tx_allow_bit_i,
    input wire [7:0] shared_serial_control_i,
    input wire [7:0] serial_control_1_i,
    input wire cts_i,
    input wire transfer_clock_pin_o,
    input wire tx_shift_empty_o,
    input wire tx_buffer_vacant_flag_o,
    input wire rx_full_o,
    input wire overrun_o,
    input wire tx_irq_o,
    input wire rx_irq_o
);
    wire cause;
    reg ovr_word_ff;
    reg ovr_prev_ff;
    assign cause = (CHANNEL == 2) ? serial_control_1_i[4] : shared_serial_control_i[CHANNEL];
    // Marks a word in which overrun was raised
    always @(posedge mclk_i) begin
        ovr_prev_ff <= overrun_o;
        if (reset_i || tx_shift_empty_o) begin
            ovr_word_ff <= 1'b0;
        end else if (overrun_o && !ovr_prev_ff) begin
            ovr_word_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    start_cond_a: assert property ($fell(tx_shift_empty_o) |->
        $past(tx_allow_bit_i) && $past(serial_mode_field_i) == 3'h1) else $error("start without enable");
    cts_gate_a: assert property ($fell(tx_shift_empty_o) && handshake_enable_i && !handshake_rts_select_i
        |-> !$past(cts_i)) else $error("start with CTS high");
    irq_load_a: assert property ($fell(tx_shift_empty_o) && !cause && !$past(tx_buffer_vacant_flag_o) |-> tx_irq_o)
        else $error("no load irq");
    irq_done_a: assert property ($rose(tx_shift_empty_o) && cause |-> tx_irq_o) else $error("no done irq");
    irq_pulse_a: assert property (tx_irq_o |=> !tx_irq_o) else $error("tx irq too long");
    rx_irq_full_a: assert property (rx_irq_o |-> rx_full_o) else $error("rx irq without data");
    ovr_needs_full_a: assert property ($rose(overrun_o) |-> $past(rx_full_o) && !tx_shift_empty_o)
        else $error("overrun without full buffer");
    ovr_no_irq_a: assert property (rx_irq_o |-> !ovr_word_ff) else $error("rx irq on overrun");
    clk_idle_a: assert property (tx_shift_empty_o && $past(tx_shift_empty_o, 2) && !clock_origin_select_i &&
        $stable(clock_edge_select_i) |-> transfer_clock_pin_o == !clock_edge_select_i) else $error("clock not idle");
    ovr_seen_c: cover property ($rose(overrun_o));
    rx_done_c: cover property (rx_irq_o);
    done_irq_c: cover property (tx_irq_o && cause);
endmodule // sync_serial_sva

bind sync_serial_channel sync_serial_sva #(.CHANNEL(CHANNEL)) u_sva (.mclk_i, .reset_i, .serial_mode_field_i,
    .clock_origin_select_i, .clock_edge_select_i, .handshake_enable_i, .handshake_rts_select_i, .tx_allow_bit_i,
    .shared_serial_control_i, .serial_control_1_i, .cts_i, .transfer_clock_pin_o, .tx_shift_empty_o,
    .tx_buffer_vacant_flag_o, .rx_full_o,
    .overrun_o, .tx_irq_o, .rx_irq_o);
